//--- verilog/can_stat_regs.svh
`ifndef CAN_STAT_REGS_SVH
`define CAN_STAT_REGS_SVH

// ----------------------------------------------------------------
// Register map: each register owns a 16-byte slot
// ----------------------------------------------------------------
`define OFS_PENDING 8'h00
`define OFS_OVERFLOW 8'h10
`define OFS_TIMER 8'h20
`define OFS_MASK0 8'h30
`define SLOT_PENDING 4'h0
`define SLOT_OVERFLOW 4'h1
`define SLOT_TIMER 4'h2
`define SLOT_MASK0 4'h3
`define SLOT_MASK3 4'h6

// ----------------------------------------------------------------
// Alias offsets inside a slot, word index in paddr[3:2]
// ----------------------------------------------------------------
`define ALIAS_BASE 2'h0
`define ALIAS_CLEAR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INVERT 2'h3

// ----------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------
`define RESET_WORD 32'h0000_0000
`define TIMER_WRITABLE 32'hffff_ffff
`define MASK_WRITABLE 32'hffeb_ffff

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STAMP_HI 31
`define STAMP_LO 16
`define PRESCALE_HI 15
`define PRESCALE_LO 0
`define MASK_STD_HI 31
`define MASK_STD_LO 21
`define MASK_TYPE_BIT 19
`define MASK_EXT_HI 17
`define MASK_EXT_LO 0

// ----------------------------------------------------------------
// Mode and code values
// ----------------------------------------------------------------
`define MODE_CONFIG 3'h4
`define CODE_NONE 7'h40
`define STAMP_MAX 16'hffff

`endif

//--- verilog/can_stat_pkg.sv
`default_nettype none
package can_stat_pkg;

  // Register update requested by one bus write
  typedef enum logic [2:0] {op_none, op_write, op_clear, op_set, op_invert} alias_op_t;

  // Applies a base, clear, set or invert write to the writable bits only
  function automatic logic [31:0] alias_apply(alias_op_t op, logic [31:0] old, logic [31:0] data,
                                              logic [31:0] valid);
    logic [31:0] res;
    res = old;
    case (op)
      op_write: res = (old & ~valid) | (data & valid);
      op_clear: res = old & ~(data & valid);
      op_set: res = old | (data & valid);
      op_invert: res = old ^ (data & valid);
      default: res = old;
    endcase
    return res;
  endfunction

endpackage

`default_nettype wire

//--- verilog/stamp_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_stat_regs.svh"

module stamp_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic stamp_capture_enable,
  input var can_stat_pkg::alias_op_t op,
  input wire logic [31:0] wdata,
  // State
  output logic [31:0] value,
  output logic tick,
  output logic wrap
);
  import can_stat_pkg::*;

  logic [15:0] pre_count;
  logic [16:0] next_pre_count;

  // Prescale 0 and 1 both give one step per clock
  always_comb begin
    next_pre_count = {1'b0, pre_count} + 17'h00001;
    tick = stamp_capture_enable && (next_pre_count >= {1'b0, value[`PRESCALE_HI:`PRESCALE_LO]});
    wrap = tick && (value[`STAMP_HI:`STAMP_LO] == `STAMP_MAX) && (op == op_none);
  end

  // Prescaler; any write restarts the period so software sees a full first step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_count <= 16'h0000;
    end else if (op != op_none) begin
      pre_count <= 16'h0000;
    end else if (!stamp_capture_enable) begin
      pre_count <= pre_count;
    end else if (tick) begin
      pre_count <= 16'h0000;
    end else begin
      pre_count <= next_pre_count[15:0];
    end
  end

  // Count and prescale word; a bus write wins over a step in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= `RESET_WORD;
    end else if (op != op_none) begin
      value <= alias_apply(op, value, wdata, `TIMER_WRITABLE);
    end else if (tick) begin
      value[`STAMP_HI:`STAMP_LO] <= value[`STAMP_HI:`STAMP_LO] + 16'h0001;
    end
  end
endmodule

`default_nettype wire

//--- verilog/mask_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_stat_regs.svh"

module mask_reg (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register access
  input var can_stat_pkg::alias_op_t op,
  input wire logic [31:0] wdata,
  input wire logic [2:0] operating_mode_state,
  output logic [31:0] value,
  // Identifier compare, [28:18] standard part, [17:0] extended part
  input wire logic [28:0] filter_id,
  input wire logic filter_extended_flag,
  input wire logic [28:0] msg_id,
  input wire logic msg_extended,
  output logic match
);
  import can_stat_pkg::*;

  logic std_ok;
  logic ext_ok;
  logic type_ok;

  // Writes outside configuration mode are dropped silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= `RESET_WORD;
    end else if (op != op_none && operating_mode_state == `MODE_CONFIG) begin
      value <= alias_apply(op, value, wdata, `MASK_WRITABLE);
    end
  end

  // Masked compare; a zero mask bit is don't-care
  always_comb begin
    std_ok = ((value[`MASK_STD_HI:`MASK_STD_LO] & (filter_id[28:18] ^ msg_id[28:18])) == 11'h000);
    ext_ok = ((value[`MASK_EXT_HI:`MASK_EXT_LO] & (filter_id[17:0] ^ msg_id[17:0])) == 18'h00000);
    type_ok = !value[`MASK_TYPE_BIT] || (filter_extended_flag == msg_extended);
    match = type_ok && std_ok && (ext_ok || !msg_extended);
  end
endmodule

`default_nettype wire

//--- verilog/can_stat_timer_masks.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_stat_regs.svh"

// Notes on behaviour
// - Pending register mirrors per-FIFO enabled interrupt pending levels, read only.
// - Word at slot plus 0x4 clears written-one bits of the base register.
// - Word at slot plus 0x8 sets written-one bits of the base register.
// - Word at slot plus 0xC toggles written-one bits of the base register.
// - Overflow register mirrors per-FIFO receive overflow levels, read only.
// - Sixteen-bit stamp count in bits 31-16 steps while capture is enabled.
// - Prescale field 15-0 sets the step period; zero steps every clock.
// - Timer register holds still while capture enable is low.
// - Any timer write restarts the prescaler, prescale field untouched.
// - Four acceptance masks, each usable in filter compares.
// - Mask bits 31-21 select standard identifier bits that must match.
// - Mask bits 17-0 select extended identifier bits that must match.
// - Mask bit 19 set demands frame type equal filter extended flag.
// - Mask bits 20 and 18 always read zero.
// - Mask writes land only in configuration mode, code 100.
// - All these registers reset to zero.
// - Stamp count overflow raises the timer overflow flag.
// - Interrupt code reports the lowest pending FIFO number.
module can_stat_timer_masks #(
  parameter int NUM_FIFOS = 32,
  parameter int NUM_MASKS = 4
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller state, same clock
  input wire logic [31:0] fifo_irq_pending,
  input wire logic [31:0] rx_overflow_flags,
  input wire logic stamp_capture_enable,
  input wire logic [2:0] operating_mode_state,
  // Identifier compare request
  input wire logic [1:0] mask_select,
  input wire logic [28:0] filter_id,
  input wire logic filter_extended_flag,
  input wire logic [28:0] msg_id,
  input wire logic msg_extended,
  // Results
  output logic filter_match,
  output logic [6:0] interrupt_code,
  output logic stamp_overflow_flag,
  output logic [15:0] stamp_count
);
  import can_stat_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_FIFOS != 32) begin : g_fifo_check
    $error("NUM_FIFOS must be 32");
  end
  if (NUM_MASKS != 4) begin : g_mask_check
    $error("NUM_MASKS must be 4");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] pending_q;
  logic [31:0] overflow_q;
  logic [31:0] timer_value;
  logic timer_tick;
  logic timer_wrap;
  logic [31:0] mask_value [NUM_MASKS];
  logic [NUM_MASKS-1:0] mask_match;
  alias_op_t bus_op;
  alias_op_t timer_op;
  alias_op_t mask_op [NUM_MASKS];
  logic [3:0] slot;
  logic [1:0] alias_idx;
  logic [1:0] mask_idx;
  logic is_mask;
  logic mapped;
  logic wr_fire;
  logic [31:0] next_prdata;
  logic [6:0] next_code;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Slot in paddr[7:4], alias word in paddr[3:2]
  always_comb begin
    slot = paddr[7:4];
    alias_idx = paddr[3:2];
    is_mask = (slot >= `SLOT_MASK0) && (slot <= `SLOT_MASK3);
    mask_idx = 2'(slot - `SLOT_MASK0);
    mapped = (paddr[1:0] == 2'h0) &&
             (slot == `SLOT_PENDING || slot == `SLOT_OVERFLOW || slot == `SLOT_TIMER || is_mask);
    wr_fire = psel && penable && pwrite && pready;
    if (alias_idx == `ALIAS_CLEAR) begin
      bus_op = op_clear;
    end else if (alias_idx == `ALIAS_SET) begin
      bus_op = op_set;
    end else if (alias_idx == `ALIAS_INVERT) begin
      bus_op = op_invert;
    end else begin
      bus_op = op_write;
    end
  end

  // Per-register write requests; status slots take no writes
  always_comb begin
    timer_op = (wr_fire && mapped && slot == `SLOT_TIMER) ? bus_op : op_none;
    for (int i = 0; i < NUM_MASKS; i++) begin
      mask_op[i] = (wr_fire && mapped && is_mask && mask_idx == 2'(i)) ? bus_op : op_none;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Alias reads give zero, software must not rely on them
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (!pwrite && mapped && alias_idx == `ALIAS_BASE) begin
      if (slot == `SLOT_PENDING) begin
        next_prdata = pending_q;
      end else if (slot == `SLOT_OVERFLOW) begin
        next_prdata = overflow_q;
      end else if (slot == `SLOT_TIMER) begin
        next_prdata = timer_value;
      end else if (is_mask) begin
        next_prdata = mask_value[mask_idx];
      end
    end
  end

  // One registered answer per setup: pready is high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable) ? next_prdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Status mirrors
  // ----------------------------------------------------------------
  // Pure mirrors of FIFO logic; alias writes have no writable bits here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= `RESET_WORD;
      overflow_q <= `RESET_WORD;
    end else begin
      pending_q <= fifo_irq_pending;
      overflow_q <= rx_overflow_flags;
    end
  end

  // Lowest pending FIFO wins the code
  always_comb begin
    next_code = `CODE_NONE;
    for (int i = NUM_FIFOS - 1; i >= 0; i--) begin
      if (pending_q[i]) begin
        next_code = 7'(i);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_code <= `CODE_NONE;
    end else begin
      interrupt_code <= next_code;
    end
  end

  // ----------------------------------------------------------------
  // Time-stamp timer
  // ----------------------------------------------------------------
  stamp_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .stamp_capture_enable(stamp_capture_enable),
    .op(timer_op),
    .wdata(pwdata),
    .value(timer_value),
    .tick(timer_tick),
    .wrap(timer_wrap)
  );

  // Overflow pulse lines up with the count reading zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_overflow_flag <= 1'b0;
    end else begin
      stamp_overflow_flag <= timer_wrap;
    end
  end

  assign stamp_count = timer_value[`STAMP_HI:`STAMP_LO];

  // ----------------------------------------------------------------
  // Acceptance masks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_MASKS; g++) begin : g_mask
    mask_reg u_mask (
      .pclk(pclk),
      .presetn(presetn),
      .op(mask_op[g]),
      .wdata(pwdata),
      .operating_mode_state(operating_mode_state),
      .value(mask_value[g]),
      .filter_id(filter_id),
      .filter_extended_flag(filter_extended_flag),
      .msg_id(msg_id),
      .msg_extended(msg_extended),
      .match(mask_match[g])
    );
  end

  // Registered so the compare path stays off the caller's timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_match <= 1'b0;
    end else begin
      filter_match <= mask_match[mask_select];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic mask0_wr;
  assign mask0_wr = wr_fire && mapped && is_mask && mask_idx == 2'h0 && operating_mode_state == `MODE_CONFIG;

  pending_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pending_q == $past(fifo_irq_pending)) else $error("pending bits do not follow FIFO logic");

  mask_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask0_wr && alias_idx == `ALIAS_CLEAR |=> (mask_value[0] & $past(pwdata)) == 32'h0000_0000)
    else $error("clear alias left a bit set");

  mask_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask0_wr && alias_idx == `ALIAS_SET |=>
    (mask_value[0] & $past(pwdata) & `MASK_WRITABLE) == ($past(pwdata) & `MASK_WRITABLE))
    else $error("set alias missed a bit");

  mask_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask0_wr && alias_idx == `ALIAS_INVERT |=>
    mask_value[0] == ($past(mask_value[0]) ^ ($past(pwdata) & `MASK_WRITABLE)))
    else $error("invert alias wrong");

  overflow_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 overflow_q == $past(rx_overflow_flags)) else $error("overflow bits do not follow FIFO logic");

  timer_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
    stamp_capture_enable && timer_value[15:0] == 16'h0000 && timer_op == op_none
    |=> stamp_count == 16'($past(stamp_count) + 16'h0001)) else $error("prescale zero must step every clock");

  timer_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !stamp_capture_enable && timer_op == op_none |=> $stable(timer_value)) else $error("timer moved while frozen");

  prescale_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_op != op_none |=> u_timer.pre_count == 16'h0000) else $error("write did not restart prescaler");

  mask_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((mask_value[0] | mask_value[1] | mask_value[2] | mask_value[3]) & 32'h0014_0000) == 32'h0000_0000)
    else $error("unimplemented mask bit set");

  mask_locked_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && is_mask && mask_idx == 2'h0 && operating_mode_state != `MODE_CONFIG |=> $stable(mask_value[0]))
    else $error("mask changed outside configuration mode");

  stamp_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_wrap |=> stamp_overflow_flag && stamp_count == 16'h0000) else $error("wrap not flagged");

  code_fifo0_a: assert property (@(posedge pclk) disable iff (!presetn)
    pending_q[0] |=> interrupt_code == 7'h00) else $error("FIFO 0 not reported");

  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready) else $error("pready timing wrong");

  mask_write_c: cover property (@(posedge pclk) disable iff (!presetn) mask0_wr);
  stamp_wrap_c: cover property (@(posedge pclk) disable iff (!presetn) timer_wrap);
  bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
  pending_read_c: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && slot == `SLOT_PENDING && prdata != 32'h0000_0000);
endmodule

`default_nettype wire

//--- tb/can_node_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------
// Remote node traffic seen by the status block
// ------------------------------------------------
module can_node_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Frame requests from the bench
  input wire logic send,
  input wire logic frame_on,
  input wire logic clr,
  input wire logic [28:0] frame_id,
  input wire logic frame_ext,
  input wire logic [4:0] frame_fifo,
  input wire logic frame_ovf,
  // Toward the block
  output logic [28:0] msg_id,
  output logic msg_extended,
  output logic [31:0] fifo_irq_pending,
  output logic [31:0] rx_overflow_flags
);
  logic [28:0] last_id;
  logic last_ext;

  // A delivered frame leaves its FIFO pending, maybe overflowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_irq_pending <= 32'h0000_0000;
      rx_overflow_flags <= 32'h0000_0000;
      last_id <= 29'h0000_0000;
      last_ext <= 1'b0;
    end else if (clr) begin
      fifo_irq_pending <= 32'h0000_0000;
      rx_overflow_flags <= 32'h0000_0000;
    end else if (send) begin
      fifo_irq_pending[frame_fifo] <= 1'b1;
      rx_overflow_flags[frame_fifo] <= rx_overflow_flags[frame_fifo] | frame_ovf;
      last_id <= frame_id;
      last_ext <= frame_ext;
    end
  end

  // Outside a frame the identifier is not held, so show its inverse
  assign msg_id = frame_on ? last_id : ~last_id;
  assign msg_extended = frame_on ? last_ext : ~last_ext;
endmodule
`default_nettype wire

//--- tb/can_stat_timer_masks_test.sv
`timescale 1ns/1ps
`default_nettype none

module can_stat_timer_masks_test;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, fifo_irq_pending, rx_overflow_flags, q;
  logic stamp_capture_enable, filter_extended_flag, msg_extended, filter_match, stamp_overflow_flag;
  logic [2:0] operating_mode_state;
  logic [1:0] mask_select;
  logic [28:0] filter_id, msg_id, frame_id;
  logic [6:0] interrupt_code;
  logic [15:0] stamp_count;
  logic send, frame_on, frame_ext, frame_ovf, clr;
  logic [4:0] frame_fifo;
  int err_count, n_tests;

  can_stat_timer_masks uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_irq_pending(fifo_irq_pending), .rx_overflow_flags(rx_overflow_flags),
    .stamp_capture_enable(stamp_capture_enable), .operating_mode_state(operating_mode_state),
    .mask_select(mask_select), .filter_id(filter_id), .filter_extended_flag(filter_extended_flag),
    .msg_id(msg_id), .msg_extended(msg_extended), .filter_match(filter_match),
    .interrupt_code(interrupt_code), .stamp_overflow_flag(stamp_overflow_flag), .stamp_count(stamp_count));

  can_node_model node (.pclk(pclk), .presetn(presetn), .send(send), .frame_on(frame_on), .clr(clr),
    .frame_id(frame_id), .frame_ext(frame_ext), .frame_fifo(frame_fifo), .frame_ovf(frame_ovf),
    .msg_id(msg_id), .msg_extended(msg_extended), .fifo_irq_pending(fifo_irq_pending),
    .rx_overflow_flags(rx_overflow_flags));

  // 200 MHz system clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    $display("BAD %0t wait ran out: %s", $time, what);
    err_count++;
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      err_count++;
    end
  endtask

  // One APB transfer; an idle edge first keeps transfers from colliding
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      hang("bus answer");
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp, what);
  endtask

  task automatic node_send(input logic [4:0] f, input logic ovf, input logic [28:0] id, input logic ext);
    @(posedge pclk);
    send <= 1'b1;
    frame_fifo <= f;
    frame_ovf <= ovf;
    frame_id <= id;
    frame_ext <= ext;
    @(posedge pclk);
    send <= 1'b0;
  endtask

  task automatic node_clear;
    @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset;
    rd(8'h00, 32'h0, "pending after reset");
    rd(8'h10, 32'h0, "overflow after reset");
    rd(8'h20, 32'h0, "timer after reset");
    for (int i = 0; i < 4; i++) begin
      rd(8'h30 + 8'(i * 16), 32'h0, "mask after reset");
    end
    chk({25'h0, interrupt_code}, 32'h40, "idle code");
  endtask

  // Alias reads carry no state, so none is compared
  task automatic t_status;
    node_send(5'd31, 1'b0, 29'h0, 1'b0);
    node_send(5'd4, 1'b1, 29'h0, 1'b0);
    repeat (4) @(posedge pclk);
    chk({25'h0, interrupt_code}, 32'h4, "lowest pending fifo");
    for (int k = 0; k < 4; k++) begin
      wr(8'h00 + 8'(k * 4), 32'hffff_ffff);
      wr(8'h10 + 8'(k * 4), 32'hffff_ffff);
    end
    rd(8'h00, 32'h8000_0010, "pending mirror");
    rd(8'h10, 32'h0000_0010, "overflow mirror");
    node_clear();
    repeat (4) @(posedge pclk);
    chk({25'h0, interrupt_code}, 32'h40, "code with none pending");
    rd(8'h00, 32'h0, "pending cleared");
  endtask

  task automatic t_timer_alias;
    wr(8'h20, 32'h1234_00f0);
    wr(8'h28, 32'h0000_000f);
    rd(8'h20, 32'h1234_00ff, "timer set alias");
    wr(8'h24, 32'h0004_0000);
    rd(8'h20, 32'h1230_00ff, "timer clear alias");
    wr(8'h2c, 32'hffff_0000);
    rd(8'h20, 32'hedcf_00ff, "timer invert alias");
    repeat (20) @(posedge pclk);
    rd(8'h20, 32'hedcf_00ff, "timer frozen");
  endtask

  // Steps counted over whole prescale periods, so phase does not matter
  task automatic t_timer_rate;
    logic [15:0] s0;
    wr(8'h20, 32'h0000_0003);
    stamp_capture_enable <= 1'b1;
    repeat (4) @(posedge pclk);
    s0 = stamp_count;
    repeat (12) @(posedge pclk);
    chk({16'h0, stamp_count - s0}, 32'd4, "prescale 3 rate");
    wr(8'h20, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    s0 = stamp_count;
    repeat (10) @(posedge pclk);
    chk({16'h0, stamp_count - s0}, 32'd10, "prescale 0 rate");
  endtask

  task automatic t_timer_restart;
    wr(8'h20, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    wr(8'h20, 32'h0000_0004);
    repeat (4) @(posedge pclk);
    chk({16'h0, stamp_count}, 32'h0, "no step before period");
    @(posedge pclk);
    chk({16'h0, stamp_count}, 32'h1, "step after period");
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({16'h0, q[15:0]}, 32'h4, "prescale kept");
  endtask

  task automatic t_timer_wrap;
    int n;
    wr(8'h20, 32'hfffd_0000);
    n = 0;
    while (stamp_overflow_flag !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      hang("stamp overflow");
    end
    chk({16'h0, stamp_count}, 32'h0, "wrap to zero");
    repeat (3) @(posedge pclk);
    chk({16'h0, stamp_count}, 32'h3, "count on after wrap");
    chk({31'h0, stamp_overflow_flag}, 32'h0, "overflow pulse ended");
    stamp_capture_enable <= 1'b0;
  endtask

  task automatic t_masks;
    logic [31:0] m [4];
    m = '{32'hffe0_0000, 32'hffe8_0000, 32'h0003_ffff, 32'h0000_0000};
    operating_mode_state <= 3'b010;
    wr(8'h30, 32'hffff_ffff);
    rd(8'h30, 32'h0, "mask write outside config");
    operating_mode_state <= 3'b100;
    for (int i = 0; i < 4; i++) begin
      wr(8'h30 + 8'(i * 16), 32'hffff_ffff);
      rd(8'h30 + 8'(i * 16), 32'hffeb_ffff, "mask unused bits");
    end
    wr(8'h34, 32'h0008_0001);
    rd(8'h30, 32'hffe3_fffe, "mask clear alias");
    wr(8'h38, 32'h001c_0000);
    rd(8'h30, 32'hffeb_fffe, "mask set alias");
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h30, 32'h0000_0001, "mask invert alias");
    for (int i = 0; i < 4; i++) begin
      wr(8'h30 + 8'(i * 16), m[i]);
    end
    operating_mode_state <= 3'b000;
    wr(8'h60, 32'hffff_ffff);
    rd(8'h60, 32'h0, "mask held outside config");
  endtask

  // Filter is an extended frame; each row picks a mask and a message
  task automatic t_match;
    logic [1:0] sel [7];
    logic [28:0] id [7];
    logic [6:0] ext, exp;
    sel = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd3};
    id = '{{11'h123, 18'h3ffff}, {11'h122, 18'h00abc}, {11'h123, 18'h00abc}, {11'h123, 18'h3ffff},
           {11'h000, 18'h00abc}, {11'h123, 18'h00abd}, {11'h7ff, 18'h3ffff}};
    ext = 7'b0111000;
    exp = 7'b1011001;
    filter_id <= {11'h123, 18'h00abc};
    filter_extended_flag <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      node_send(5'd0, 1'b0, id[i], ext[i]);
      frame_on <= 1'b1;
      mask_select <= sel[i];
      repeat (3) @(posedge pclk);
      chk({31'h0, filter_match}, {31'h0, exp[i]}, "filter compare");
      frame_on <= 1'b0;
    end
    node_clear();
  endtask

  task automatic t_bus_err;
    apb(1'b0, 8'h70, 32'h0000_0000);
    chk({31'h0, e}, 32'h1, "unmapped read error");
    apb(1'b1, 8'h22, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1, "unaligned write error");
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk({31'h0, e}, 32'h0, "mapped read no error");
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stamp_capture_enable = 1'b0;
    operating_mode_state = 3'b000;
    mask_select = 2'd0;
    filter_id = 29'h0;
    filter_extended_flag = 1'b0;
    send = 1'b0;
    frame_on = 1'b0;
    clr = 1'b0;
    frame_id = 29'h0;
    frame_ext = 1'b0;
    frame_fifo = 5'd0;
    frame_ovf = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_timer_alias();
    t_timer_rate();
    t_timer_restart();
    t_timer_wrap();
    t_masks();
    t_match();
    t_bus_err();
    give_verdict();
  end
endmodule
`default_nettype wire
